//--- rtl/display_output_channel.sv
// Purpose: Output channel sending stored display words bit-serially to a display console
// Assumes: Console word-request line is asynchronous; link lines are registered outputs
// Behaviour
// - Status shows whether the channel is transmitting.
// - Unacknowledged word is resent with normal framing about 5.6 ms later.
// - Acknowledged resend resumes the ordinary word-by-word sequence.
// - A failed first resend leads to a second resend of the same word.
// - After failed second resend wait 5.6 ms, raise word-valid one word, then abort.
// - Word-request stuck high runs the retry path to abort.
// - Word-request low between load and first word aborts the message.
// - No new request within 3 s after an acknowledged word aborts.
// - After abort the channel ignores word-request and sends no more words.
// - Abort marks remaining blocks obsolete, enters error state, raises display event.
// - Status tells successful end from abort.
// - Status shows console present while word-request is high.
// - Next word starts at a 5.6 ms multiple after the previous word ended.
// - Word-valid high during data, dropped at the end of the 56th bit.
// - Last acknowledged word marks its block obsolete, ends transmission, raises event.
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "dochan_regs.svh"
`default_nettype none
module display_output_channel #(
    parameter int unsigned SLOT_CYC = `DOC_SLOT_US * 1000 / `DOC_CLK_NS,
    parameter int unsigned FIRST_CYC = `DOC_FIRST_US * 1000 / `DOC_CLK_NS,
    parameter int unsigned ACKWIN_CYC = `DOC_ACKWIN_US * 1000 / `DOC_CLK_NS,
    parameter int unsigned TMO_CYC = 32'(`DOC_TMO_MS * 64'd1000000 / `DOC_CLK_NS)
) (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    // Register port
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    // Console link
    output logic WORD_VALID_LINE_O,
    output logic SERIAL_WORD_LINE_O,
    output logic BIT_STROBE_LINE_O,
    input wire logic WORD_REQUEST_LINE_I,
    // Display event towards the processor
    output logic DISPLAY_INT_O
);
    import dochan_pkg::*;

    localparam logic [8:0] BIT_LAST = 9'(`DOC_BIT_CYC - 1);
    localparam logic [8:0] STB_ON = 9'(`DOC_STB_ON);
    localparam logic [8:0] STB_OFF = 9'(`DOC_STB_ON + `DOC_STB_CYC);

    // Word store, two blocks of eight words
    logic [`DOC_WORD_BITS-1:0] mem_q [`DOC_WORDS];
    logic [31:0] wlo_q;
    logic [3:0] wr_idx_q;
    logic [4:0] len_q;

    chan_state_t state_q;
    logic [31:0] timer_q;
    logic [31:0] slot_q;
    logic [8:0] phase_q;
    logic [5:0] bit_q;
    logic [`DOC_WORD_BITS-1:0] shift_q;
    logic [3:0] widx_q;
    logic [1:0] retry_q;
    logic acked_q;
    logic [`DOC_BLOCKS-1:0] obsolete_q;
    chan_status_t status_q;
    link_out_t link_q;
    logic int_q;
    logic [31:0] rdata_q;
    logic req_s;

    logic start_w;
    logic clr_w;
    logic word_end;
    logic slot_end;
    logic last_word;
    logic [3:0] next_idx;

    // Register write decode
    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = WR_I && (ADDR_I == a);
    endfunction

    // Request line crosses into the system clock domain
    dochan_sync u_req_sync (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RST_N_I),
        .d_i(WORD_REQUEST_LINE_I),
        .q_o(req_s)
    );

    assign start_w = wr_hit(`DOC_ADDR_CTRL) && WDATA_I[`DOC_CTRL_START];
    assign clr_w = wr_hit(`DOC_ADDR_CTRL) && WDATA_I[`DOC_CTRL_CLR];
    assign word_end = (phase_q == BIT_LAST) && (bit_q == `DOC_LAST_BIT);
    assign slot_end = (slot_q == SLOT_CYC - 1);
    assign last_word = ({1'b0, widx_q} == len_q - 5'h01);
    assign next_idx = widx_q + 4'h1;

    // Software loading of the word store and message length
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            wlo_q <= `DOC_ZERO32;
            wr_idx_q <= 4'h0;
            len_q <= 5'h00;
        end else begin
            if (wr_hit(`DOC_ADDR_WLO)) begin
                wlo_q <= WDATA_I;
            end
            if (wr_hit(`DOC_ADDR_WIDX)) begin
                wr_idx_q <= WDATA_I[3:0];
            end else if (wr_hit(`DOC_ADDR_WHI)) begin
                wr_idx_q <= wr_idx_q + 4'h1; // Auto-advance for streaming loads
            end
            if (wr_hit(`DOC_ADDR_LEN) && state_q == ST_IDLE) begin
                len_q <= WDATA_I[4:0];
            end
        end
    end

    // Store array has no reset; words are written before a message starts
    always_ff @(posedge CLK_SYS_I) begin
        if (wr_hit(`DOC_ADDR_WHI)) begin
            mem_q[wr_idx_q] <= {WDATA_I[`DOC_HI_BITS-1:0], wlo_q};
        end
    end

    // Sequencer with its interval counters
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            state_q <= ST_IDLE;
            timer_q <= `DOC_ZERO32;
            slot_q <= `DOC_ZERO32;
            phase_q <= 9'h000;
            bit_q <= 6'h00;
            shift_q <= '0;
            widx_q <= 4'h0;
            retry_q <= 2'h0;
            acked_q <= 1'b0;
            obsolete_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // Request line is ignored here, also after an abort
                    if (start_w && len_q != 5'h00) begin
                        state_q <= ST_LOAD;
                        timer_q <= `DOC_ZERO32;
                        widx_q <= 4'h0;
                        retry_q <= 2'h0;
                        obsolete_q <= '0;
                    end
                end
                ST_LOAD: begin
                    timer_q <= timer_q + 32'h1;
                    if (!req_s) begin
                        state_q <= ST_CLEAN; // Console vanished before first word
                    end else if (timer_q == SLOT_CYC + FIRST_CYC - 1) begin
                        state_q <= ST_SEND;
                        shift_q <= mem_q[widx_q];
                        phase_q <= 9'h000;
                        bit_q <= 6'h00;
                    end
                end
                ST_SEND, ST_DUMMY: begin
                    // Bits go out least significant first, one per bit period
                    if (phase_q == BIT_LAST) begin
                        phase_q <= 9'h000;
                        bit_q <= bit_q + 6'h01;
                        shift_q <= shift_q >> 1;
                    end else begin
                        phase_q <= phase_q + 9'h001;
                    end
                    if (word_end) begin
                        timer_q <= `DOC_ZERO32;
                        slot_q <= `DOC_ZERO32;
                        acked_q <= 1'b0;
                        state_q <= (state_q == ST_DUMMY) ? ST_CLEAN : ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    timer_q <= timer_q + 32'h1;
                    slot_q <= slot_end ? `DOC_ZERO32 : slot_q + 32'h1;
                    if (!acked_q && !req_s && timer_q < ACKWIN_CYC) begin
                        // Low request inside the window is the acknowledge
                        acked_q <= 1'b1;
                        retry_q <= 2'h0;
                        if (last_word) begin
                            obsolete_q[widx_q[3]] <= 1'b1;
                            state_q <= ST_DONE;
                        end
                    end else if (acked_q && timer_q >= TMO_CYC - 1) begin
                        state_q <= ST_CLEAN; // No new request in time
                    end else if (slot_end && acked_q && req_s) begin
                        // Next word on a slot boundary after the last word ended
                        if (next_idx[3] != widx_q[3]) begin
                            obsolete_q[widx_q[3]] <= 1'b1; // Finished block is released
                        end
                        widx_q <= next_idx;
                        shift_q <= mem_q[next_idx];
                        phase_q <= 9'h000;
                        bit_q <= 6'h00;
                        state_q <= ST_SEND;
                    end else if (slot_end && !acked_q) begin
                        // Stuck-high request or bad word both land here
                        phase_q <= 9'h000;
                        bit_q <= 6'h00;
                        if (retry_q < `DOC_MAX_RETRY) begin
                            retry_q <= retry_q + 2'h1;
                            shift_q <= mem_q[widx_q];
                            state_q <= ST_SEND;
                        end else begin
                            shift_q <= '0;
                            state_q <= ST_DUMMY;
                        end
                    end
                end
                ST_CLEAN: begin
                    obsolete_q <= '1; // Every block left of the message is dropped
                    state_q <= ST_IDLE;
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Link lines, registered so the console sees clean levels
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            link_q <= '0;
        end else begin
            // Valid covers the whole word, last bit cycle included, so bit 55 is full length
            link_q.valid <= (state_q == ST_SEND) || (state_q == ST_DUMMY);
            link_q.data <= (state_q == ST_SEND) && shift_q[0];
            // Strobe centred in each bit; the closing word before abort has none
            link_q.strobe <= (state_q == ST_SEND) &&
                (phase_q >= STB_ON) && (phase_q < STB_OFF);
        end
    end

    // Channel status and display event; the hardware set wins over a clear
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            status_q <= '0;
            int_q <= 1'b0;
        end else begin
            status_q.busy <= (state_q != ST_IDLE) || start_w;
            status_q.present <= req_s;
            int_q <= (state_q == ST_CLEAN) || (state_q == ST_DONE);
            if (state_q == ST_CLEAN) begin
                status_q.aborted <= 1'b1;
                status_q.event_seen <= 1'b1;
            end else if (state_q == ST_DONE) begin
                status_q.done <= 1'b1;
                status_q.event_seen <= 1'b1;
            end else begin
                if (clr_w) begin
                    status_q.event_seen <= 1'b0;
                end
                if (start_w && state_q == ST_IDLE) begin
                    status_q.aborted <= 1'b0;
                    status_q.done <= 1'b0;
                end
            end
        end
    end

    // Read data stands in the cycle after the read strobe only
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            rdata_q <= `DOC_ZERO32;
        end else if (RD_I) begin
            case (ADDR_I)
                `DOC_ADDR_STATUS: rdata_q <= {27'h0, status_q};
                `DOC_ADDR_LEN: rdata_q <= {27'h0, len_q};
                `DOC_ADDR_WLO: rdata_q <= wlo_q;
                `DOC_ADDR_WIDX: rdata_q <= {28'h0, wr_idx_q};
                `DOC_ADDR_OBS: rdata_q <= {30'h0, obsolete_q};
                default: rdata_q <= `DOC_ZERO32;
            endcase
        end else begin
            rdata_q <= `DOC_ZERO32;
        end
    end

    assign RDATA_O = rdata_q;
    assign WORD_VALID_LINE_O = link_q.valid;
    assign SERIAL_WORD_LINE_O = link_q.data;
    assign BIT_STROBE_LINE_O = link_q.strobe;
    assign DISPLAY_INT_O = int_q;
endmodule
`default_nettype wire

//--- rtl/dochan_regs.svh
// Purpose: Register offsets, field positions and timing figures of the display output channel
// Assumes: 100 MHz system clock, 32-bit register port with byte addresses
// Notes: Definitions only; included by bare name
`ifndef DOCHAN_REGS_SVH
`define DOCHAN_REGS_SVH

// Register byte addresses
`define DOC_ADDR_CTRL 8'h00
`define DOC_ADDR_STATUS 8'h04
`define DOC_ADDR_LEN 8'h08
`define DOC_ADDR_WLO 8'h0C
`define DOC_ADDR_WHI 8'h10
`define DOC_ADDR_WIDX 8'h14
`define DOC_ADDR_OBS 8'h18

// Control fields
`define DOC_CTRL_START 0
`define DOC_CTRL_CLR 1

// Status fields
`define DOC_ST_BUSY 0
`define DOC_ST_ABORT 1
`define DOC_ST_PRESENT 2
`define DOC_ST_DONE 3
`define DOC_ST_EVENT 4

// Word and store geometry
`define DOC_WORD_BITS 56
`define DOC_HI_BITS 24
`define DOC_WORDS 16
`define DOC_BLOCKS 2
`define DOC_LAST_BIT 6'h37
`define DOC_MAX_RETRY 2'h2
`define DOC_ZERO32 32'h0000_0000

// Timing figures in their own units
`define DOC_CLK_NS 10
`define DOC_BIT_NS 2809
`define DOC_STB_NS 500
`define DOC_SLOT_US 5600
`define DOC_FIRST_US 300
`define DOC_ACKWIN_US 4500
`define DOC_TMO_MS 3000

// Derived cycle counts
`define DOC_BIT_CYC (`DOC_BIT_NS / `DOC_CLK_NS)
`define DOC_STB_CYC ((`DOC_STB_NS + `DOC_CLK_NS - 1) / `DOC_CLK_NS)
`define DOC_STB_ON ((`DOC_BIT_CYC - `DOC_STB_CYC) / 2)

`endif

//--- rtl/dochan_pkg.sv
// Purpose: Types shared by the display output channel files
// Assumes: Nothing beyond the register header
// Notes: Gray codes along idle, load, send, wait
package dochan_pkg;

    // Channel sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_LOAD  = 3'h1,
        ST_SEND  = 3'h3,
        ST_WAIT  = 3'h2,
        ST_DUMMY = 3'h6,
        ST_CLEAN = 3'h7,
        ST_DONE  = 3'h5
    } chan_state_t;

    // Lines driven towards the console
    typedef struct packed {
        logic valid;
        logic data;
        logic strobe;
    } link_out_t;

    // Channel status as seen by software
    typedef struct packed {
        logic event_seen;
        logic done;
        logic present;
        logic aborted;
        logic busy;
    } chan_status_t;

endpackage

//--- rtl/dochan_sync.sv
// Purpose: Two-stage synchroniser for a level arriving from outside the clock domain
// Assumes: Synchronous active-low reset
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module dochan_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Level in and out
    input wire logic d_i,
    output logic q_o
);
    logic meta_q;
    logic sync_q;

    // Two flops; the first one is never looked at by anything else
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule
`default_nettype wire

//--- dv/dochan_props.sv
// Purpose: Port-level checks on the display output channel
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to the design at the foot of this file
`timescale 1ns/1ps
`include "dochan_regs.svh"
`default_nettype none
module dochan_props #(
    parameter int unsigned SLOT_CYC = 200
) (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    // Register port
    input wire logic [7:0] ADDR_I,
    input wire logic RD_I,
    input wire logic [31:0] RDATA_O,
    // Console link and event
    input wire logic WORD_VALID_LINE_O,
    input wire logic BIT_STROBE_LINE_O,
    input wire logic WORD_REQUEST_LINE_I,
    input wire logic DISPLAY_INT_O
);
    localparam int WORD_CYC = `DOC_WORD_BITS * `DOC_BIT_CYC;
    localparam int STB_CYC = `DOC_STB_CYC;
    int vcnt_q, scnt_q, swid_q;
    logic [31:0] gap_q;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    // Word length, strobes per word, strobe width; the gap saturates so reset looks long idle
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            vcnt_q <= 0;
            scnt_q <= 0;
            swid_q <= 0;
            gap_q <= 32'hFFFF_FFFF;
        end else begin
            vcnt_q <= WORD_VALID_LINE_O ? vcnt_q + 1 : 0;
            scnt_q <= WORD_VALID_LINE_O ? scnt_q + int'($rose(BIT_STROBE_LINE_O)) : 0;
            swid_q <= BIT_STROBE_LINE_O ? swid_q + 1 : 0;
            gap_q <= WORD_VALID_LINE_O ? 32'h0 : gap_q + 32'(gap_q != 32'hFFFF_FFFF);
        end
    end
    AST_WORD_LEN: assert property ($fell(WORD_VALID_LINE_O) |-> vcnt_q == WORD_CYC)
        else $error("word-valid length wrong");
    AST_BITS_PER_WORD: assert property ($fell(WORD_VALID_LINE_O) |-> scnt_q inside {0, 56})
        else $error("strobe count per word wrong");
    AST_STROBE_IN_WORD: assert property (BIT_STROBE_LINE_O |-> WORD_VALID_LINE_O)
        else $error("strobe outside word");
    AST_STROBE_WIDTH: assert property ($fell(BIT_STROBE_LINE_O) |-> swid_q == STB_CYC)
        else $error("strobe width wrong");
    AST_SLOT_GAP: assert property ($rose(WORD_VALID_LINE_O) |-> gap_q >= SLOT_CYC - 1)
        else $error("word started before slot");
    AST_INT_PULSE: assert property (DISPLAY_INT_O |=> !DISPLAY_INT_O)
        else $error("event longer than one cycle");
    AST_QUIET_AFTER_INT: assert property (DISPLAY_INT_O |-> !WORD_VALID_LINE_O [*8])
        else $error("word sent after end of message");
    AST_RDATA_IDLE: assert property (!RD_I |=> RDATA_O == 32'h0)
        else $error("read data outside read slot");
    AST_PRESENT: assert property (WORD_REQUEST_LINE_I [*5] ##0
        (RD_I && ADDR_I == `DOC_ADDR_STATUS) |=> RDATA_O[`DOC_ST_PRESENT])
        else $error("console present bit low");
    cover property ($fell(WORD_VALID_LINE_O) && scnt_q == 56);
    cover property ($fell(WORD_VALID_LINE_O) && scnt_q == 0);
    cover property (DISPLAY_INT_O);
endmodule
bind display_output_channel dochan_props #(.SLOT_CYC(SLOT_CYC)) u_props (
    .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .WORD_VALID_LINE_O(WORD_VALID_LINE_O), .BIT_STROBE_LINE_O(BIT_STROBE_LINE_O),
    .WORD_REQUEST_LINE_I(WORD_REQUEST_LINE_I), .DISPLAY_INT_O(DISPLAY_INT_O));
`default_nettype wire

//--- dv/console_model.sv
// Purpose: Behavioural display console receiving words from the channel
// Assumes: Mode is changed between scenarios, and once inside the early-drop scenario while the channel loads
// Notes: Modes 0 ack, 1 never ack, 2 ack then stay low, 3 line held low
`timescale 1ns/1ps
`default_nettype none
module console_model (
    // Pacing clock and behaviour
    input wire logic clk_i,
    input wire logic [1:0] mode_i,
    // Lines from the channel
    input wire logic valid_i,
    input wire logic data_i,
    input wire logic strobe_i,
    // Request line and received data
    output logic req_o,
    output logic [55:0] word_o,
    output var int bits_o,
    output var int words_o
);
    initial begin
        req_o = 1'b1;
        word_o = 56'h0;
        bits_o = 0;
        words_o = 0;
    end
    // A word without strobes leaves the count at zero
    always @(posedge valid_i) bits_o = 0;
    // Least significant bit first, taken on the strobe
    always @(posedge strobe_i) begin
        word_o = {data_i, word_o[55:1]};
        bits_o = bits_o + 1;
    end
    // Resting level of the request line for the chosen behaviour
    always @(mode_i) req_o <= (mode_i != 2'h3);
    // Only a complete word is acknowledged; a withheld ack leaves the line at its resting level
    always @(negedge valid_i) begin
        words_o = words_o + 1;
        if (mode_i != 2'h1 && mode_i != 2'h3 && bits_o == 56 &&
            word_o != 56'h0) begin // All-zero data reads as a parity error
            repeat (10) @(posedge clk_i);
            req_o <= 1'b0;
            repeat (20) @(posedge clk_i);
            if (mode_i == 2'h0) req_o <= 1'b1;
        end
    end // Mode 1 never acks mode 2 stays low
endmodule
`default_nettype wire

//--- dv/display_output_channel_error_control_test.sv
// Purpose: Scenario bench for the display output channel
// Assumes: Shortened interval parameters; word timing is fixed by the bit period
// Notes: Each scenario task drives one scenario and judges it before returning
`timescale 1ns/1ps
`include "dochan_regs.svh"
`default_nettype none
module display_output_channel_error_control_test;
    localparam int SLOT = 200;
    localparam int TMO = 2000;
    localparam int WORD_CYC = `DOC_WORD_BITS * `DOC_BIT_CYC;
    logic CLK_SYS_I, RST_N_I, WR_I, RD_I, WORD_VALID_LINE_O, SERIAL_WORD_LINE_O;
    logic BIT_STROBE_LINE_O, WORD_REQUEST_LINE_I, DISPLAY_INT_O;
    logic [7:0] ADDR_I;
    logic [31:0] WDATA_I, RDATA_O;
    logic [1:0] mode;
    logic [55:0] rx_word;
    int rx_bits, rx_words, error_cnt, checks, n, w;
    display_output_channel #(.SLOT_CYC(SLOT), .FIRST_CYC(20), .ACKWIN_CYC(150), .TMO_CYC(TMO)) uut (
        .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
        .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .WORD_VALID_LINE_O(WORD_VALID_LINE_O),
        .SERIAL_WORD_LINE_O(SERIAL_WORD_LINE_O), .BIT_STROBE_LINE_O(BIT_STROBE_LINE_O),
        .WORD_REQUEST_LINE_I(WORD_REQUEST_LINE_I), .DISPLAY_INT_O(DISPLAY_INT_O));
    console_model u_console (.clk_i(CLK_SYS_I), .mode_i(mode), .valid_i(WORD_VALID_LINE_O),
        .data_i(SERIAL_WORD_LINE_O), .strobe_i(BIT_STROBE_LINE_O), .req_o(WORD_REQUEST_LINE_I),
        .word_o(rx_word), .bits_o(rx_bits), .words_o(rx_words));
    initial begin
        CLK_SYS_I = 1'b0;
        forever #5 CLK_SYS_I = ~CLK_SYS_I;
    end
    function automatic logic [55:0] exp_word(input int i);
        return {24'h5A1E00 + 24'(i), 32'hA5C3_0F00 + 32'(i)};
    endfunction
    task automatic end_sim();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Register cycles leave a quiet cycle so no strobe is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ADDR_I <= a;
        WDATA_I <= d;
        WR_I <= 1'b1;
        @(posedge CLK_SYS_I);
        WR_I <= 1'b0;
        @(posedge CLK_SYS_I);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        ADDR_I <= a;
        RD_I <= 1'b1;
        @(posedge CLK_SYS_I);
        RD_I <= 1'b0;
        @(posedge CLK_SYS_I);
        check(64'(RDATA_O & m), 64'(e));
    endtask
    // Counts edges until word-valid (sel 0) or the event (sel 1) shows the wanted level
    task automatic wait_line(input logic sel, input logic want, input int lim, output int cnt);
        cnt = 0;
        while ((sel ? DISPLAY_INT_O : WORD_VALID_LINE_O) !== want) begin
            @(posedge CLK_SYS_I);
            cnt++;
            if (cnt > lim) begin
                error_cnt++;
                $display("BAD t=%0t wait ran out", $time);
                end_sim();
            end
        end
    endtask
    task automatic start(input int words);
        logic [55:0] v;
        wr(`DOC_ADDR_CTRL, 32'h0000_0002);
        wr(`DOC_ADDR_WIDX, 32'h0);
        for (int i = 0; i < words; i++) begin
            v = exp_word(i);
            wr(`DOC_ADDR_WLO, v[31:0]);
            wr(`DOC_ADDR_WHI, {8'h00, v[55:32]});
        end
        wr(`DOC_ADDR_LEN, 32'(words));
        wr(`DOC_ADDR_CTRL, 32'h0000_0001);
    endtask
    task automatic t_good();
        rd(8'hFC, 32'hFFFF_FFFF, 32'h0);
        rd(`DOC_ADDR_STATUS, 32'h0000_001F, 32'h0000_0004);
        start(1);
        rd(`DOC_ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
        wait_line(1'b0, 1'b1, 400, n);
        check(64'(n >= 210 && n <= 225), 64'h1);
        wait_line(1'b0, 1'b0, WORD_CYC + 10, n);
        check(64'(rx_word), 64'(exp_word(0)));
        wait_line(1'b1, 1'b1, 300, n);
        rd(`DOC_ADDR_STATUS, 32'h0000_001B, 32'h0000_0018);
        rd(`DOC_ADDR_OBS, 32'h0000_0001, 32'h0000_0001);
        $display("good message finished");
    endtask
    task automatic t_retry();
        mode <= 2'h1;
        start(2);
        for (int k = 0; k < 4; k++) begin
            wait_line(1'b0, 1'b1, 2000, n);
            if (k > 0) check(64'(n >= SLOT - 2 && n <= SLOT + 3), 64'h1);
            wait_line(1'b0, 1'b0, WORD_CYC + 10, n);
            check(64'(rx_bits), (k < 3) ? 64'h38 : 64'h0);
            if (k < 3) check(64'(rx_word), 64'(exp_word(0)));
        end
        wait_line(1'b1, 1'b1, 100, n);
        rd(`DOC_ADDR_STATUS, 32'h0000_001B, 32'h0000_0012);
        rd(`DOC_ADDR_OBS, 32'h0000_0003, 32'h0000_0003);
        w = rx_words;
        repeat (3 * SLOT) @(posedge CLK_SYS_I);
        check(64'(rx_words), 64'(w));
        $display("retry abort finished");
    endtask
    task automatic t_timeout();
        mode <= 2'h2;
        start(2);
        wait_line(1'b0, 1'b1, 600, n);
        wait_line(1'b0, 1'b0, WORD_CYC + 10, n);
        w = rx_words;
        wait_line(1'b1, 1'b1, TMO + 200, n);
        check(64'(n >= TMO - 5 && n <= TMO + 20), 64'h1);
        check(64'(rx_words), 64'(w));
        rd(`DOC_ADDR_STATUS, 32'h0000_001B, 32'h0000_0012);
        $display("timeout finished");
    endtask
    task automatic t_early();
        mode <= 2'h0;
        wr(`DOC_ADDR_CTRL, 32'h0000_0002);
        repeat (5) @(posedge CLK_SYS_I);
        w = rx_words;
        wr(`DOC_ADDR_CTRL, 32'h0000_0001);
        repeat (50) @(posedge CLK_SYS_I);
        mode <= 2'h3;
        wait_line(1'b1, 1'b1, 400, n);
        check(64'(rx_words), 64'(w));
        rd(`DOC_ADDR_STATUS, 32'h0000_001F, 32'h0000_0012);
        $display("early drop finished");
    endtask
    initial begin
        error_cnt = 0;
        checks = 0;
        mode = 2'h0;
        RST_N_I = 1'b0;
        WR_I = 1'b0;
        RD_I = 1'b0;
        ADDR_I = 8'h00;
        WDATA_I = 32'h0;
        repeat (3) @(posedge CLK_SYS_I);
        RST_N_I <= 1'b1;
        repeat (6) @(posedge CLK_SYS_I);
        t_good();
        t_retry();
        t_timeout();
        t_early();
        end_sim();
    end
endmodule
`default_nettype wire
